// ==== core/logic_pkg.sv ====
package logic_pkg;

  // Sizes of the connector set and of the gate array.
  localparam int NGATE = 4;     // Number of configurable basic gates.
  localparam int NIN = 24;      // Digital inputs, base terminals first.
  localparam int NBASE = 8;     // Base unit input terminals.
  localparam int NOUT = 16;     // Digital outputs.
  localparam int NFLAG = 24;    // Digital flags.
  localparam int NAFLAG = 6;    // Analog flags.
  localparam int NSHIFT = 8;    // Shift bits.
  localparam int AW = 10;       // Analog value width.
  localparam int NGIN = 4;      // Inputs per gate.

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_AOUT = 8'h0C;
  localparam logic [7:0] REG_ASEL = 8'h10;
  localparam logic [7:0] REG_GCFG = 8'h20;
  localparam logic [7:0] REG_GDST = 8'h30;

  // Field positions.
  localparam int CTRL_RUN = 0;
  localparam int CFG_INV_LSB = 24;
  localparam int CFG_TYPE_LSB = 28;
  localparam int ASEL_AQ1_LSB = 16;
  localparam int ASEL_AQ2_LSB = 20;
  localparam int ST_FIRST = 16;
  localparam int ST_GOUT_LSB = 17;
  localparam int ST_SHIFT_LSB = 21;
  localparam int AOUT_AQ2_LSB = 16;

  // Reset values: every gate input open, no destination, no analog source.
  localparam logic [31:0] CFG_RST = 32'h00FFFFFF;
  localparam logic [5:0] DST_RST = 6'h3F;
  localparam logic [31:0] ASEL_RST = 32'h00770000;

  // Connector source codes for gate inputs.
  localparam logic [5:0] SRC_FLAG = 6'h18;
  localparam logic [5:0] SRC_SHIFT = 6'h30;
  localparam logic [5:0] SRC_HI = 6'h38;
  localparam logic [5:0] SRC_LO = 6'h39;

  // Destination codes for gate outputs.
  localparam logic [5:0] DST_FLAG = 6'h10;
  localparam logic [5:0] DST_BLANK = 6'h28;

  // Gate function codes.
  localparam logic [1:0] GT_AND = 2'h0;
  localparam logic [1:0] GT_AND_EDGE = 2'h1;
  localparam logic [1:0] GT_NAND = 2'h2;

  // Analog flag source codes.
  localparam logic [1:0] AS_AI1 = 2'h1;
  localparam logic [1:0] AS_AI2 = 2'h2;

  localparam int STARTUP_IDX = 7;        // Flag used as the startup flag.
  localparam logic DUAL_USE_EN = 1'b1;   // Inputs seven and eight are dual use.

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // All state of the block.
  typedef struct packed {
    logic run;
    logic first;
    logic [NFLAG-1:0] flags;
    logic [NOUT-1:0] dout;
    logic [NGATE-1:0] gout;
    logic [NGATE-1:0][NGIN-1:0] prev;
    logic [NSHIFT-1:0] shift;
    logic [NAFLAG-1:0][AW-1:0] aflag;
    logic [1:0][AW-1:0] aout;
    logic [NGATE-1:0][31:0] cfg;
    logic [NGATE-1:0][5:0] dst;
    logic [31:0] asel;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

endpackage

// ==== core/cyclic_logic_gate_blocks.sv ====
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
module cyclic_logic_gate_blocks
  import logic_pkg::*;
(
  input wire logic clk_sys, // System clock, 25 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic [7:0] awaddr, // Write address.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write byte strobes.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  output logic [1:0] bresp, // Write response.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  input wire logic [7:0] araddr, // Read address.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response.
  output logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  input wire logic cycle_tick, // One-cycle strobe ending a program cycle.
  input wire logic [NBASE-1:0] base_in, // Base unit input terminals.
  input wire logic [NIN-NBASE-1:0] exp_in, // Expansion inputs, installation order.
  input wire logic [AW-1:0] analog_input_first, // Analog value of input seven.
  input wire logic [AW-1:0] analog_input_second, // Analog value of input eight.
  input wire logic shift_load, // Shift function writes shift bits.
  input wire logic [NSHIFT-1:0] shift_val, // New shift bit values.
  output logic [NOUT-1:0] dig_out, // Digital outputs, base first.
  output logic [NFLAG-1:0] flag_out, // Digital flag values.
  output logic startup_flag, // Startup flag value.
  output logic [AW-1:0] analog_output_first, // First analog output.
  output logic [AW-1:0] analog_output_second // Second analog output.
);

  // The whole block state lives in one packed struct.
  state_s s_q; // Registered state.
  state_s s_d; // Next state.
  logic aw_hs; // Write address and data taken together.
  logic ar_hs; // Read address taken.

  // Merges a write into an old word under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    // Byte lanes without a strobe keep their old contents.
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // The slave takes a write only with both address and data present.
  // A pending response blocks the next request of its own kind.
  assign aw_hs = awvalid & wvalid & ~s_q.bvalid;
  assign ar_hs = arvalid & ~s_q.rvalid;
  assign awready = aw_hs;
  assign wready = aw_hs;
  assign arready = ar_hs;

  // Next-state logic: bus slave, program cycle evaluation and flags.
  always_comb begin
    // Working values of one evaluation; each gets a default below.
    logic [63:0] conn;
    logic [NGIN-1:0] gin;
    logic [5:0] sel;
    logic [5:0] dst;
    logic [5:0] fidx;
    logic [2:0] aqs;
    logic [1:0] as;
    logic gval;
    logic all_hi;
    logic [AW-1:0] ai1;
    logic [AW-1:0] ai2;
    logic [31:0] wm;
    // Defaults come first, so that no path leaves a latch behind.
    conn = '1;
    gin = '0;
    sel = '0;
    dst = '0;
    fidx = '0;
    aqs = '0;
    as = '0;
    gval = 1'b0;
    all_hi = 1'b0;
    ai1 = '0;
    ai2 = '0;
    wm = '0;
    // Every field holds its value unless a branch below moves it.
    s_d = s_q;
    // Input indices run over base terminals, then expansion modules.
    conn[NIN-1:0] = {exp_in, base_in};
    // Gates read flags as stored last cycle.
    conn[SRC_FLAG +: NFLAG] = s_q.flags;
    conn[SRC_SHIFT +: NSHIFT] = s_q.shift;
    // Constant levels sit at fixed source codes.
    conn[SRC_HI] = 1'b1;
    conn[SRC_LO] = 1'b0;
    // Inputs seven and eight give analog values when so addressed.
    ai1 = DUAL_USE_EN ? analog_input_first : '0;
    ai2 = DUAL_USE_EN ? analog_input_second : '0;

    // Write channel: decode, merge strobes, answer.
    if (aw_hs) begin
      // The response is raised at the edge that takes the request.
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      // Gate configuration words sit at four consecutive offsets.
      if ({awaddr[7:4], 4'h0} == REG_GCFG) begin
        s_d.cfg[awaddr[3:2]] = merge(s_q.cfg[awaddr[3:2]], wdata, wstrb);
      end else if ({awaddr[7:4], 4'h0} == REG_GDST) begin
        // Only the low byte lane reaches the destination code.
        wm = merge({26'h0, s_q.dst[awaddr[3:2]]}, wdata, wstrb);
        s_d.dst[awaddr[3:2]] = wm[5:0];
      end else if ({awaddr[7:2], 2'h0} == REG_CTRL) begin
        wm = merge({31'h0, s_q.run}, wdata, wstrb);
        s_d.run = wm[CTRL_RUN];
      end else if ({awaddr[7:2], 2'h0} == REG_ASEL) begin
        // Source selection for the analog flags and outputs.
        s_d.asel = merge(s_q.asel, wdata, wstrb);
      end else if (({awaddr[7:2], 2'h0} == REG_STATUS) ||
                   ({awaddr[7:2], 2'h0} == REG_FLAGS) ||
                   ({awaddr[7:2], 2'h0} == REG_AOUT)) begin
        // Read-only state: shift bits and flags cannot be written here.
        s_d.bresp = RESP_OKAY;
      end else begin
        // Unmapped address.
        s_d.bresp = RESP_SLVERR;
      end
    end else if (s_q.bvalid && bready) begin
      // The master has taken the write response.
      s_d.bvalid = 1'b0;
    end

    // Read channel: data is registered and held until taken.
    if (ar_hs) begin
      // Read data is captured at the taking edge and then held.
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = '0;
      if ({araddr[7:4], 4'h0} == REG_GCFG) begin
        s_d.rdata = s_q.cfg[araddr[3:2]];
      end else if ({araddr[7:4], 4'h0} == REG_GDST) begin
        s_d.rdata[5:0] = s_q.dst[araddr[3:2]];
      end else begin
        case ({araddr[7:2], 2'h0})
          REG_CTRL: begin
            s_d.rdata[CTRL_RUN] = s_q.run;
          end
          REG_STATUS: begin
            s_d.rdata[NOUT-1:0] = s_q.dout;
            s_d.rdata[ST_FIRST] = s_q.first;
            s_d.rdata[ST_GOUT_LSB +: NGATE] = s_q.gout;
            s_d.rdata[ST_SHIFT_LSB +: NSHIFT] = s_q.shift;
          end
          REG_FLAGS: begin
            s_d.rdata[NFLAG-1:0] = s_q.flags;
          end
          REG_AOUT: begin
            s_d.rdata[AW-1:0] = s_q.aout[0];
            s_d.rdata[AOUT_AQ2_LSB +: AW] = s_q.aout[1];
          end
          REG_ASEL: begin
            s_d.rdata = s_q.asel;
          end
          default: begin
            // An unmapped read answers with an error and zero data.
            s_d.rresp = RESP_SLVERR;
          end
        endcase
      end
    end else if (s_q.rvalid && rready) begin
      // The master has taken the read data.
      s_d.rvalid = 1'b0;
    end

    // One evaluation of every block per program cycle strobe.
    if (cycle_tick && s_q.run) begin
      if (s_q.first) begin
        // First cycle over: startup flag drops unless a gate sets it.
        s_d.first = 1'b0;
        s_d.flags[STARTUP_IDX] = 1'b0;
      end
      for (int g = 0; g < NGATE; g++) begin
        for (int k = 0; k < NGIN; k++) begin
          sel = s_q.cfg[g][6*k +: 6];
          // Open codes read high; each input may be inverted.
          gin[k] = conn[sel] ^ s_q.cfg[g][CFG_INV_LSB + k];
        end
        // All inputs high, after inversion, is shared by every gate type.
        all_hi = &gin;
        case (s_q.cfg[g][CFG_TYPE_LSB +: 2])
          GT_AND: begin
            gval = all_hi;
          end
          GT_AND_EDGE: begin
            // Pulse only in the cycle the conjunction newly becomes true.
            gval = all_hi & ~(&s_q.prev[g]);
          end
          GT_NAND: begin
            gval = ~all_hi;
          end
          default: begin
            gval = all_hi;
          end
        endcase
        // Inputs as seen now become the history for the next evaluation.
        s_d.prev[g] = gin;
        s_d.gout[g] = gval;
        // Route the result to its configured destination.
        dst = s_q.dst[g];
        if (dst < DST_FLAG) begin
          // Output indices run over base terminals, then expansions.
          s_d.dout[dst[3:0]] = gval;
        end else if (dst < DST_BLANK) begin
          // Flags forward what was applied; startup flag included.
          fidx = dst - DST_FLAG;
          s_d.flags[fidx[4:0]] = gval;
        end else begin
          // Blank output: value reaches no terminal or flag; only gout keeps it.
          s_d.gout[g] = gval;
        end
      end
      // Analog flags take their source and show it next cycle.
      for (int i = 0; i < NAFLAG; i++) begin
        // Codes other than the two inputs leave the flag unchanged.
        as = s_q.asel[2*i +: 2];
        if (as == AS_AI1) begin
          s_d.aflag[i] = ai1;
        end else if (as == AS_AI2) begin
          s_d.aflag[i] = ai2;
        end
      end
      // Analog outputs only accept analog flags; other codes give zero.
      for (int j = 0; j < 2; j++) begin
        aqs = s_q.asel[(j == 0 ? ASEL_AQ1_LSB : ASEL_AQ2_LSB) +: 3];
        s_d.aout[j] = (aqs < 3'(NAFLAG)) ? s_q.aflag[aqs] : '0;
      end
    end

    // Only the shift function changes shift bits.
    if (shift_load) begin
      s_d.shift = shift_val;
    end

    // Start of program run: startup flag high through the first cycle.
    // Placed last, so that it wins over a tick in the same edge.
    if (s_d.run && !s_q.run) begin
      s_d.first = 1'b1;
      s_d.flags[STARTUP_IDX] = 1'b1;
    end
  end

  // State register; all history clears to zero on reset.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      // Configuration resets to open inputs and blank destinations.
      s_q.cfg <= {NGATE{CFG_RST}};
      s_q.dst <= {NGATE{DST_RST}};
      s_q.asel <= ASEL_RST;
    end else begin
      // Every register runs on every clock edge.
      s_q <= s_d;
    end
  end

  // Outputs straight from state flip-flops.
  assign dig_out = s_q.dout;
  assign flag_out = s_q.flags;
  assign startup_flag = s_q.flags[STARTUP_IDX];
  assign analog_output_first = s_q.aout[0];
  assign analog_output_second = s_q.aout[1];
  // Bus responses also come straight from flip-flops.
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;

endmodule // cyclic_logic_gate_blocks

// ==== sim/gate_props.sv ====
`timescale 1ns/100ps
// Port-level checker for the gate block.
module gate_props
  import logic_pkg::*;
(
  input wire logic clk_sys, // Clock.
  input wire logic arst_n, // Reset, active low.
  input wire logic awvalid, // Write address valid.
  input wire logic awready, // Write address ready.
  input wire logic wready, // Write data ready.
  input wire logic wvalid, // Write data valid.
  input wire logic [1:0] bresp, // Write response.
  input wire logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  input wire logic arvalid, // Read address valid.
  input wire logic arready, // Read address ready.
  input wire logic [31:0] rdata, // Read data.
  input wire logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  input wire logic cycle_tick, // Cycle strobe.
  input wire logic [NOUT-1:0] dig_out, // Digital outputs.
  input wire logic [NFLAG-1:0] flag_out, // Flags.
  input wire logic startup_flag, // Startup flag.
  input wire logic [AW-1:0] analog_output_first // First analog output.
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic wr_take; // A write is accepted at this edge.
  assign wr_take = awvalid && wvalid && awready;
  a_write_answer: assert property (wr_take |=> bvalid)
    else $error("write not answered next cycle");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered next cycle");
  a_bresp_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_write_refused: assert property (bvalid |-> !awready)
    else $error("write taken while response pending");
  a_write_ready: assert property (awvalid && wvalid && !bvalid |-> awready && wready)
    else $error("free write not accepted");
  a_read_ready: assert property (arvalid && !rvalid |-> arready)
    else $error("free read not accepted");
  a_flags_held: assert property (!cycle_tick && !wr_take |=> $stable(flag_out))
    else $error("flags moved inside a cycle");
  a_outs_held: assert property (!cycle_tick |=> $stable(dig_out))
    else $error("outputs moved without strobe");
  a_aout_held: assert property (!cycle_tick |=> $stable(analog_output_first))
    else $error("analog output moved without strobe");
  a_startup_alias: assert property (startup_flag == flag_out[STARTUP_IDX])
    else $error("startup flag differs from its flag");
  c_write: cover property (wr_take);
  c_tick_out: cover property (cycle_tick ##1 dig_out[0]);
  c_startup: cover property ($rose(startup_flag));
endmodule // gate_props

bind cyclic_logic_gate_blocks gate_props i_gate_props (.clk_sys, .arst_n, .awvalid, .awready,
  .wready, .wvalid, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
  .cycle_tick, .dig_out, .flag_out, .startup_flag, .analog_output_first);

// ==== sim/field_io.sv ====
`timescale 1ns/100ps
// Field terminals: switches settle one clock after the bench moves them.
module field_io
  import logic_pkg::*;
(
  input wire logic clk_sys, // Clock.
  input wire logic [NIN-1:0] sw, // Switch levels, terminal order.
  input wire logic [AW-1:0] a_in, // Sensor value at input seven.
  output logic [NBASE-1:0] base_in, // Base terminals.
  output logic [NIN-NBASE-1:0] exp_in, // Expansion terminals.
  output logic [AW-1:0] ai_first, // Analog value of input seven.
  output logic [AW-1:0] ai_second // Analog value of input eight.
);
  // Terminals numbered base first, then expansions.
  always_ff @(posedge clk_sys) begin
    {exp_in, base_in} <= sw;
    ai_first <= a_in; // Shares terminal seven.
    ai_second <= ~a_in; // Sensor at terminal eight reads the inverse.
  end
endmodule // field_io

// ==== sim/tb.sv ====
`timescale 1ns/100ps
module tb
  import logic_pkg::*;
;
  logic clk_sys = 1'b0, arst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, cycle_tick = 1'b0, shift_load = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, startup_flag;
  logic [7:0] awaddr = '0, araddr = '0, shift_val = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, r;
  logic [NIN-1:0] sw = '0;
  logic [NBASE-1:0] base_in;
  logic [NIN-NBASE-1:0] exp_in;
  logic [AW-1:0] a_in = '0, ai1, ai2, aq1, aq2;
  logic [NOUT-1:0] dig_out;
  logic [NFLAG-1:0] flag_out;
  logic [3:0] v;
  logic a, nw, pv;
  int err_count = 0, tests_run = 0, cyc = 0;
  always #20 clk_sys = ~clk_sys; // 25 MHz.
  field_io i_field_io (.clk_sys, .sw, .a_in, .base_in, .exp_in, .ai_first(ai1),
    .ai_second(ai2));
  cyclic_logic_gate_blocks i_cyclic_logic_gate_blocks (.clk_sys, .arst_n, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .cycle_tick, .base_in, .exp_in,
    .analog_input_first(ai1), .analog_input_second(ai2), .shift_load, .shift_val, .dig_out,
    .flag_out, .startup_flag, .analog_output_first(aq1), .analog_output_second(aq2));
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // AXI4-Lite write, response code checked.
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
    @(posedge clk_sys);
    awaddr <= ad; wdata <= dt; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do @(negedge clk_sys); while (awready !== 1'b1);
    @(posedge clk_sys);
    awvalid <= 1'b0; wvalid <= 1'b0;
    do @(negedge clk_sys); while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, er}, "bresp");
    @(posedge clk_sys);
    bready <= 1'b0;
  endtask
  // AXI4-Lite read.
  task automatic rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    @(posedge clk_sys);
    araddr <= ad; arvalid <= 1'b1; rready <= 1'b1;
    do @(negedge clk_sys); while (arready !== 1'b1);
    @(posedge clk_sys);
    arvalid <= 1'b0;
    do @(negedge clk_sys); while (rvalid !== 1'b1);
    dt = rdata; rs = rresp;
    @(posedge clk_sys);
    rready <= 1'b0;
  endtask
  // Set switches, then one program cycle strobe; returns where outputs are settled.
  task automatic tick(input logic [NIN-1:0] s);
    @(posedge clk_sys); sw <= s;
    @(posedge clk_sys); cycle_tick <= 1'b1;
    @(posedge clk_sys); cycle_tick <= 1'b0;
    @(negedge clk_sys);
  endtask
  function automatic logic [31:0] mk(input logic [5:0] s0, s1, s2, s3, input logic [3:0] iv,
      input logic [1:0] ty);
    return {2'h0, ty, iv, s3, s2, s1, s0};
  endfunction
  initial begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(REG_GCFG, d, r); chk(d, CFG_RST, "cfg reset");
    rd(REG_ASEL, d, r); chk(d, ASEL_RST, "asel reset");
    rd(8'h40, d, r); chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(8'h40, 32'h0, RESP_SLVERR);
    $display("test reset done");
    wr(REG_GCFG, mk(6'h00, 6'h01, 6'h02, 6'h03, 4'h0, GT_AND), RESP_OKAY);
    wr(REG_GCFG + 8'h04, mk(6'h00, 6'h01, 6'h02, 6'h03, 4'h0, GT_NAND), RESP_OKAY);
    wr(REG_GCFG + 8'h08, mk(6'h08, 6'h3F, 6'h3F, 6'h3F, 4'h0, GT_AND), RESP_OKAY);
    wr(REG_GCFG + 8'h0C, mk(6'h00, 6'h01, SRC_HI, SRC_LO, 4'h8, GT_AND_EDGE), RESP_OKAY);
    for (int g = 0; g < 4; g++) wr(REG_GDST + 8'(4 * g), 32'(g), RESP_OKAY);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    chk({31'h0, startup_flag}, 32'h1, "startup set");
    pv = 1'b0;
    for (int i = 0; i < 16; i++) begin
      v = 4'(i);
      tick({15'h0, v[0], 4'h0, v});
      a = (v == 4'hF);
      nw = v[0] & v[1];
      chk({28'h0, dig_out[3:0]}, {28'h0, nw & ~pv, v[0], ~a, a}, "gates");
      pv = nw;
    end
    chk({31'h0, startup_flag}, 32'h0, "startup cleared");
    $display("test gates done");
    wr(REG_GDST, 32'(DST_FLAG + 6'd23), RESP_OKAY);
    wr(REG_GDST + 8'h04, 32'(DST_BLANK), RESP_OKAY);
    wr(REG_GDST + 8'h08, 32'(DST_FLAG + 6'(STARTUP_IDX)), RESP_OKAY);
    tick(24'h00010F);
    chk({30'h0, flag_out[23], startup_flag}, 32'h3, "flags set");
    tick(24'h000000);
    chk({14'h0, flag_out[23], startup_flag, dig_out}, 32'h5, "flags clear");
    $display("test flags done");
    wr(REG_ASEL, 32'h00600009, RESP_OKAY);
    @(posedge clk_sys) a_in <= 10'h2A5;
    tick(24'h000000);
    chk({22'h0, aq1}, 32'h0, "analog lag");
    tick(24'h000000);
    chk({12'h0, aq1, aq2}, {12'h0, 10'h2A5, 10'h000}, "analog out");
    wr(REG_ASEL, 32'h00100009, RESP_OKAY);
    tick(24'h000000);
    chk({22'h0, aq2}, {22'h0, 10'h15A}, "analog second");
    $display("test analog done");
    @(posedge clk_sys) begin
      shift_load <= 1'b1;
      shift_val <= 8'hA5;
    end
    @(posedge clk_sys) shift_load <= 1'b0;
    wr(REG_STATUS, 32'h0, RESP_OKAY);
    rd(REG_STATUS, d, r); chk({24'h0, d[28:21]}, 32'hA5, "shift bits");
    $display("test shift done");
    tally_and_finish();
  end
endmodule // tb
